// file: design/vcc_consts.svh
// Purpose: offsets, field positions, reset values of the comparator control
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   included by the synchroniser, the top module and the bench files
`ifndef VCC_CONSTS_SVH
`define VCC_CONSTS_SVH

`define VCC_ADDR_W          12
`define VCC_OFF_ENABLE      12'h000
`define VCC_OFF_SELECT      12'h004
`define VCC_OFF_STATUS      12'h008
`define VCC_OFF_IRQ_STAT    12'h00C
`define VCC_OFF_IRQ_MASK    12'h010
`define VCC_OFF_GLOBAL      12'h014

`define VCC_BIT_ENABLE      7
`define VCC_BIT_CMP_OUT     7
`define VCC_BIT_CMP_OE      6
`define VCC_BIT_CHANGE      0
`define VCC_BIT_GLOBAL      0
`define VCC_REF_LO          0
`define VCC_REF_HI          3
`define VCC_PAD_LO          4
`define VCC_PAD_HI          7

`define VCC_RST_BYTE        8'h00
`define VCC_RST_BIT         1'b0
`define VCC_REF_PAIR        4'h0
`define VCC_PAD_NONE        4'h5
`define VCC_SYNC_STAGES     2

`endif

// file: design/vcc_pkg.sv
// Purpose: types shared by the comparator control files
// Assumes: constants come from vcc_consts.svh
// Notes:   pad codes number port A bits 0..7 then port B bits 0..7
package vcc_pkg;

  typedef enum logic [3:0] {
    PAD_A0 = 4'h0, PAD_A1 = 4'h1, PAD_A2 = 4'h2, PAD_A3 = 4'h3,
    PAD_A4 = 4'h4, PAD_A5 = 4'h5, PAD_A6 = 4'h6, PAD_A7 = 4'h7,
    PAD_B0 = 4'h8, PAD_B1 = 4'h9, PAD_B2 = 4'hA, PAD_B3 = 4'hB,
    PAD_B4 = 4'hC, PAD_B5 = 4'hD, PAD_B6 = 4'hE, PAD_B7 = 4'hF
  } vcc_pad_type;

  typedef enum logic [1:0] {
    MODE_PAD_TO_PAD = 2'b01,
    MODE_PAD_TO_REF = 2'b10
  } vcc_mode_type;

endpackage

// file: design/vcc_sync_if.sv
// Purpose: carries the comparator level into and out of the synchroniser
// Assumes: one clock domain on the consumer side
// Notes:   raw is asynchronous, sync is clean on CLK
`timescale 1ns/1ps
interface vcc_sync_if;
  logic raw;
  logic sync;
  modport stage (input raw, output sync);
  modport user  (output raw, input sync);
endinterface

// file: design/vcc_sync.sv
// Purpose: multi-flop synchroniser for the analog comparator output
// Assumes: synchronous active-high reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`include "vcc_consts.svh"
module vcc_sync #(
  parameter int STAGES = `VCC_SYNC_STAGES
) (
  input  wire logic  clk,
  input  wire logic  reset,
  vcc_sync_if.stage  lnk
);
  logic [STAGES-1:0] chain;
  logic [STAGES-1:0] next_chain;

  // refuse a chain too short to settle a metastable first stage
  if (STAGES < 2) begin : g_stages_check
    $error("vcc_sync needs at least two stages");
  end

  always_comb begin
    next_chain = {chain[STAGES-2:0], lnk.raw};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chain <= '0;
    end else begin
      chain <= next_chain;
    end
  end

  assign lnk.sync = chain[STAGES-1];
endmodule

// file: design/vcc_top.sv
// Purpose: digital control around the on-chip voltage comparator
// Assumes: APB slave, 100 MHz CLK, synchronous active-high RESET
// Notes:   no wait state on any transfer; read data comes from a flop
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "vcc_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - enable bit gates comparator, resets to off
// - halt mode forces the comparator off
// - reference field zero is pad-to-pad mode
// - reference field picks tap n/16 of supply
// - reference tap only feeds the inverting input
// - pad field picks non-inverting pad, code 5 none
// - pad-to-pad mode uses sixteen fixed pad pairs
// - pads go analog only when config selects
// - status read reloads the registered output copy
// - output differing from copy sets change flag while enabled outside halt
// - live output readable at status bit 7
// - output enable drives result onto port B bit 3
// - output enable suppresses first pulse modulator
// - change flag stays set until written zero
// - interrupt needs own enable and global enable
module vcc_top (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        HALT,
  input  wire logic        CFG_CMP_PADS,
  input  wire logic        CMP_RAW,
  input  wire logic        PMOD1_ENABLE,
  output logic             CMP_ENABLE,
  output logic [3:0]       REF_TAP_SEL,
  output logic             REF_TO_INVERTING,
  output logic [3:0]       NONINV_PAD_SEL,
  output logic             NONINV_PAD_VALID,
  output logic [3:0]       INV_PAD_SEL,
  output logic             INV_PAD_VALID,
  output logic [15:0]      ANALOG_PAD_EN,
  output logic             PORTB3_OUT,
  output logic             PORTB3_OE,
  output logic             PMOD1_GATED_EN,
  output logic             IRQ
);

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic       comparator_enable;
  logic [7:0] comparator_select_control;
  logic       comparator_output_enable;
  logic       comparator_change_flag;
  logic       comparator_interrupt_enable;
  logic       global_interrupt_enable;
  logic       cmp_copy;
  logic [31:0] rdata;

  logic       next_comparator_enable;
  logic [7:0] next_comparator_select_control;
  logic       next_comparator_output_enable;
  logic       next_comparator_change_flag;
  logic       next_comparator_interrupt_enable;
  logic       next_global_interrupt_enable;
  logic       next_cmp_copy;
  logic [31:0] next_rdata;

  logic       cmp_live;
  logic       active;
  logic       setup;
  logic       access;
  logic       wr;
  logic       rd;
  logic       mapped;
  logic [3:0] reference_select_field;
  logic [3:0] pad_select_field;
  vcc_pkg::vcc_mode_type mode;

  //////////////////////////////////////////////////////////////////////////
  // synchroniser
  vcc_sync_if sync_lnk ();
  assign sync_lnk.raw = CMP_RAW;

  vcc_sync #(.STAGES(`VCC_SYNC_STAGES)) u_sync (
    .clk   (CLK),
    .reset (RESET),
    .lnk   (sync_lnk.stage)
  );
  assign cmp_live = sync_lnk.sync;

  //////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup  = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign wr     = access & PWRITE & mapped;
  assign rd     = access & ~PWRITE & mapped;

  always_comb begin
    case (PADDR)
      `VCC_OFF_ENABLE, `VCC_OFF_SELECT, `VCC_OFF_STATUS,
      `VCC_OFF_IRQ_STAT, `VCC_OFF_IRQ_MASK, `VCC_OFF_GLOBAL: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign PREADY  = access;
  assign PSLVERR = access & ~mapped;
  assign PRDATA  = rdata;

  //////////////////////////////////////////////////////////////////////////
  // register next values
  always_comb begin
    next_comparator_enable           = comparator_enable;
    next_comparator_select_control   = comparator_select_control;
    next_comparator_output_enable    = comparator_output_enable;
    next_comparator_interrupt_enable = comparator_interrupt_enable;
    next_global_interrupt_enable     = global_interrupt_enable;
    next_comparator_change_flag      = comparator_change_flag;
    next_cmp_copy                    = cmp_copy;
    next_rdata                       = rdata;
    if (wr) begin
      case (PADDR)
        `VCC_OFF_ENABLE: begin
          next_comparator_enable = PWDATA[`VCC_BIT_ENABLE];
        end
        `VCC_OFF_SELECT: begin
          next_comparator_select_control = PWDATA[7:0];
        end
        `VCC_OFF_STATUS: begin
          next_comparator_output_enable = PWDATA[`VCC_BIT_CMP_OE];
        end
        `VCC_OFF_IRQ_STAT: begin
          if (!PWDATA[`VCC_BIT_CHANGE]) begin
            next_comparator_change_flag = 1'b0;
          end
        end
        `VCC_OFF_IRQ_MASK: begin
          next_comparator_interrupt_enable = PWDATA[`VCC_BIT_CHANGE];
        end
        `VCC_OFF_GLOBAL: begin
          next_global_interrupt_enable = PWDATA[`VCC_BIT_GLOBAL];
        end
        default: begin
          next_comparator_enable = comparator_enable;
        end
      endcase
    end
    // a status read ends the mismatch
    if (rd && PADDR == `VCC_OFF_STATUS) begin
      next_cmp_copy = cmp_live;
    end
    // set wins over a clear in the same cycle
    if (active && cmp_live != cmp_copy) begin
      next_comparator_change_flag = 1'b1;
    end
    if (setup) begin
      next_rdata = 32'h0000_0000;
      case (PADDR)
        `VCC_OFF_ENABLE: begin
          next_rdata[`VCC_BIT_ENABLE] = comparator_enable;
        end
        `VCC_OFF_SELECT: begin
          next_rdata[7:0] = comparator_select_control;
        end
        `VCC_OFF_STATUS: begin
          next_rdata[`VCC_BIT_CMP_OUT] = cmp_live;
          next_rdata[`VCC_BIT_CMP_OE]  = comparator_output_enable;
        end
        `VCC_OFF_IRQ_STAT: begin
          next_rdata[`VCC_BIT_CHANGE] = comparator_change_flag;
        end
        `VCC_OFF_IRQ_MASK: begin
          next_rdata[`VCC_BIT_CHANGE] = comparator_interrupt_enable;
        end
        `VCC_OFF_GLOBAL: begin
          next_rdata[`VCC_BIT_GLOBAL] = global_interrupt_enable;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      comparator_enable           <= `VCC_RST_BIT;
      comparator_select_control   <= `VCC_RST_BYTE;
      comparator_output_enable    <= `VCC_RST_BIT;
      comparator_interrupt_enable <= `VCC_RST_BIT;
      global_interrupt_enable     <= `VCC_RST_BIT;
      comparator_change_flag      <= `VCC_RST_BIT;
      cmp_copy                    <= `VCC_RST_BIT;
      rdata                       <= 32'h0000_0000;
    end else begin
      comparator_enable           <= next_comparator_enable;
      comparator_select_control   <= next_comparator_select_control;
      comparator_output_enable    <= next_comparator_output_enable;
      comparator_interrupt_enable <= next_comparator_interrupt_enable;
      global_interrupt_enable     <= next_global_interrupt_enable;
      comparator_change_flag      <= next_comparator_change_flag;
      cmp_copy                    <= next_cmp_copy;
      rdata                       <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // enable and mode decode
  assign active     = comparator_enable & ~HALT;
  assign CMP_ENABLE = active;

  assign reference_select_field =
    comparator_select_control[`VCC_REF_HI:`VCC_REF_LO];
  assign pad_select_field =
    comparator_select_control[`VCC_PAD_HI:`VCC_PAD_LO];

  assign mode = (reference_select_field == `VCC_REF_PAIR) ?
    vcc_pkg::MODE_PAD_TO_PAD : vcc_pkg::MODE_PAD_TO_REF;

  //////////////////////////////////////////////////////////////////////////
  // input multiplexer selects
  always_comb begin
    REF_TAP_SEL      = `VCC_REF_PAIR;
    REF_TO_INVERTING = 1'b0;
    NONINV_PAD_SEL   = vcc_pkg::PAD_A0;
    NONINV_PAD_VALID = 1'b0;
    INV_PAD_SEL      = vcc_pkg::PAD_A0;
    INV_PAD_VALID    = 1'b0;
    case (mode)
      vcc_pkg::MODE_PAD_TO_REF: begin
        // tap n of sixteen, only ever on the inverting side
        REF_TAP_SEL      = reference_select_field;
        REF_TO_INVERTING = 1'b1;
        NONINV_PAD_SEL   = pad_select_field;
        NONINV_PAD_VALID = pad_select_field != `VCC_PAD_NONE;
      end
      vcc_pkg::MODE_PAD_TO_PAD: begin
        NONINV_PAD_VALID = 1'b1;
        INV_PAD_VALID    = 1'b1;
        case (pad_select_field)
          4'h0: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_A0, vcc_pkg::PAD_A1};
          4'h1: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_A1, vcc_pkg::PAD_A0};
          4'h2: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_A2, vcc_pkg::PAD_A3};
          4'h3: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_A3, vcc_pkg::PAD_A2};
          4'h4: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_A0, vcc_pkg::PAD_B3};
          4'h5: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_A1, vcc_pkg::PAD_B2};
          4'h6: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_A2, vcc_pkg::PAD_B5};
          4'h7: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_A3, vcc_pkg::PAD_B4};
          4'h8: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_B2, vcc_pkg::PAD_A1};
          4'h9: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_B3, vcc_pkg::PAD_A0};
          4'hA: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_B4, vcc_pkg::PAD_A3};
          4'hB: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_B5, vcc_pkg::PAD_A2};
          4'hC: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_B2, vcc_pkg::PAD_B3};
          4'hD: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_B3, vcc_pkg::PAD_B2};
          4'hE: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_B4, vcc_pkg::PAD_B5};
          default: {NONINV_PAD_SEL, INV_PAD_SEL} =
            {vcc_pkg::PAD_B5, vcc_pkg::PAD_B4};
        endcase
      end
      default: begin
        REF_TAP_SEL = `VCC_REF_PAIR;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // analog pad enables, only with the config word
  always_comb begin
    ANALOG_PAD_EN = 16'h0000;
    if (CFG_CMP_PADS) begin
      if (NONINV_PAD_VALID) begin
        ANALOG_PAD_EN[NONINV_PAD_SEL] = 1'b1;
      end
      if (INV_PAD_VALID) begin
        ANALOG_PAD_EN[INV_PAD_SEL] = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output pad, modulator gating, interrupt
  assign PORTB3_OE      = comparator_output_enable;
  assign PORTB3_OUT     = comparator_output_enable & cmp_live;
  assign PMOD1_GATED_EN = PMOD1_ENABLE & ~comparator_output_enable;
  assign IRQ = comparator_change_flag & comparator_interrupt_enable &
               global_interrupt_enable;

endmodule

// file: tb/vcc_top_asserts.sv
// Purpose: port-level checks of the comparator control
// Assumes: one CLK domain, RESET synchronous active high
// Notes:   bound to vcc_top after the module
`timescale 1ns/1ps
`include "vcc_consts.svh"
//////////////////////////////////////////////////////////////////////////////
module vcc_top_asserts (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        HALT,
  input wire logic        CMP_RAW,
  input wire logic        PMOD1_ENABLE,
  input wire logic        CMP_ENABLE,
  input wire logic [3:0]  REF_TAP_SEL,
  input wire logic        REF_TO_INVERTING,
  input wire logic [3:0]  NONINV_PAD_SEL,
  input wire logic        NONINV_PAD_VALID,
  input wire logic        INV_PAD_VALID,
  input wire logic        PORTB3_OUT,
  input wire logic        PORTB3_OE,
  input wire logic        PMOD1_GATED_EN,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  logic wr;
  logic irq_wr;
  assign wr = PSEL && PENABLE && PWRITE;
  assign irq_wr = wr && PADDR >= `VCC_OFF_IRQ_STAT;
  //////////////////////////////////////////////////////////////////////////////
  enable_write_a:
    assert property (wr && PADDR == `VCC_OFF_ENABLE |=>
      CMP_ENABLE == ($past(PWDATA[7]) && !HALT)) else $error("enable bad");
  halt_off_a:
    assert property (HALT |-> !CMP_ENABLE) else $error("enabled in halt");
  tap_write_a:
    assert property (wr && PADDR == `VCC_OFF_SELECT |=>
      REF_TAP_SEL == $past(PWDATA[3:0]) &&
      REF_TO_INVERTING == ($past(PWDATA[3:0]) != 4'h0)) else $error("tap bad");
  tap_inv_only_a:
    assert property (REF_TO_INVERTING |-> !INV_PAD_VALID)
      else $error("inverting pad in reference mode");
  no_pad_a:
    assert property (REF_TO_INVERTING |->
      NONINV_PAD_VALID == (NONINV_PAD_SEL != `VCC_PAD_NONE))
      else $error("pad valid bad");
  pad_follow_a:
    assert property ((PORTB3_OE && CMP_RAW) [*3] |-> PORTB3_OUT)
      else $error("pad output not following");
  sync_delay_a:
    assert property ($rose(CMP_RAW) |=> !PORTB3_OUT)
      else $error("no sync delay");
  pwm_gate_a:
    assert property (PMOD1_GATED_EN == (PMOD1_ENABLE && !PORTB3_OE))
      else $error("modulator gate bad");
  irq_hold_a:
    assert property (IRQ && !irq_wr |=> IRQ) else $error("irq dropped");
  global_off_a:
    assert property (wr && PADDR == `VCC_OFF_GLOBAL && !PWDATA[0] |=> !IRQ)
      else $error("irq without global enable");
  cover property ($rose(IRQ));
  cover property ($rose(PORTB3_OUT));
  cover property (HALT && !CMP_ENABLE);
endmodule

bind vcc_top vcc_top_asserts u_vcc_top_asserts (
  .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .HALT(HALT),
  .CMP_RAW(CMP_RAW), .PMOD1_ENABLE(PMOD1_ENABLE), .CMP_ENABLE(CMP_ENABLE),
  .REF_TAP_SEL(REF_TAP_SEL), .REF_TO_INVERTING(REF_TO_INVERTING),
  .NONINV_PAD_SEL(NONINV_PAD_SEL), .NONINV_PAD_VALID(NONINV_PAD_VALID),
  .INV_PAD_VALID(INV_PAD_VALID), .PORTB3_OUT(PORTB3_OUT),
  .PORTB3_OE(PORTB3_OE), .PMOD1_GATED_EN(PMOD1_GATED_EN), .IRQ(IRQ));

// file: tb/tb_voltage_comparator_control.sv
// Purpose: self-checking bench for the comparator control
// Assumes: APB answers within 15 access cycles
// Notes:   select codes walked, then random
`timescale 1ns/1ps
`include "vcc_consts.svh"
//////////////////////////////////////////////////////////////////////////////
module tb_voltage_comparator_control;
  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, halt = 1'b0, cfg = 1'b0, raw = 1'b0;
  logic        pmod = 1'b0, pready, pslverr, cmp_en, ref_inv, nv, iv;
  logic        pbo, pboe, pmod_g, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  tap, nsel, isel;
  logic [15:0] apen;
  int          n_mismatch = 0, samples_checked = 0;
  localparam logic [63:0] p2p_ni  = 64'hDCBA_DCBA_3210_3210;
  localparam logic [63:0] p2p_inv = 64'hCDAB_2301_CDAB_2301;

  always #5 clk = ~clk;

  vcc_top u_vcc_top (.CLK(clk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .HALT(halt),
    .CFG_CMP_PADS(cfg), .CMP_RAW(raw), .PMOD1_ENABLE(pmod),
    .CMP_ENABLE(cmp_en), .REF_TAP_SEL(tap), .REF_TO_INVERTING(ref_inv),
    .NONINV_PAD_SEL(nsel), .NONINV_PAD_VALID(nv), .INV_PAD_SEL(isel),
    .INV_PAD_VALID(iv), .ANALOG_PAD_EN(apen), .PORTB3_OUT(pbo),
    .PORTB3_OE(pboe), .PMOD1_GATED_EN(pmod_g), .IRQ(irq));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results;
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      results;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  function automatic logic [31:0] sel_exp(input logic [7:0] v, input logic c);
    logic [3:0] r, p, n, i;
    logic       ev, iv_e;
    logic [15:0] an;
    r = v[3:0];
    p = v[7:4];
    n = (r == 4'h0) ? p2p_ni[p*4 +: 4] : p;
    i = p2p_inv[p*4 +: 4];
    ev = (r == 4'h0) || (p != `VCC_PAD_NONE);
    iv_e = (r == 4'h0);
    an = 16'h0000;
    if (c && ev) an[n] = 1'b1;
    if (c && iv_e) an[i] = 1'b1;
    return {an, r, r != 4'h0, ev, iv_e, 1'b0, ev ? n : 4'h0, iv_e ? i : 4'h0};
  endfunction

  initial begin
    int i;
    logic [7:0] v;
    logic [31:0] rt;
    void'($urandom(28386));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0000_0000);
      chk("reset value", 32'h0000_0000, rd);
    end
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk("unmapped data", 32'h0000_0000, rd);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    $display("test reset done");
    apb(1'b1, `VCC_OFF_ENABLE, 32'h0000_0080);
    settle(0);
    chk("enable", 32'h0000_0001, {31'h0, cmp_en});
    @(posedge clk) halt <= 1'b1;
    settle(0);
    chk("halt", 32'h0000_0000, {31'h0, cmp_en});
    @(posedge clk) halt <= 1'b0;
    $display("test enable done");
    for (i = 0; i < 48; i++) begin
      v = (i < 16) ? {i[3:0], 4'h0} : (i == 16) ? 8'h53 : 8'($urandom);
      apb(1'b1, `VCC_OFF_SELECT, {24'h0, v});
      cfg <= (i < 16) | 1'($urandom);
      settle(0);
      rt = {apen, tap, ref_inv, nv, iv, 1'b0, nv ? nsel : 4'h0,
            iv ? isel : 4'h0};
      chk("route", sel_exp(v, cfg), rt);
      apb(1'b0, `VCC_OFF_SELECT, 32'h0000_0000);
      chk("select", {24'h0, v}, rd);
    end
    $display("test routing done");
    pmod <= 1'b1;
    settle(0);
    chk("pwm open", 32'h0000_0002, {30'h0, pmod_g, pboe});
    apb(1'b1, `VCC_OFF_STATUS, 32'h0000_0040);
    settle(0);
    chk("pwm gate", 32'h0000_0001, {30'h0, pmod_g, pboe});
    @(posedge clk) raw <= 1'b1;
    settle(1);
    chk("sync", 32'h0000_0000, {31'h0, pbo});
    settle(1);
    chk("pad out", 32'h0000_0001, {31'h0, pbo});
    apb(1'b0, `VCC_OFF_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_00C0, rd);
    $display("test pad done");
    apb(1'b1, `VCC_OFF_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, `VCC_OFF_GLOBAL, 32'h0000_0001);
    apb(1'b1, `VCC_OFF_IRQ_STAT, 32'h0000_0000);
    settle(3);
    chk("irq idle", 32'h0000_0000, {31'h0, irq});
    @(posedge clk) raw <= 1'b0;
    settle(4);
    chk("irq set", 32'h0000_0001, {31'h0, irq});
    apb(1'b0, `VCC_OFF_STATUS, 32'h0000_0000);
    chk("status low", 32'h0000_0040, rd);
    apb(1'b1, `VCC_OFF_IRQ_STAT, 32'h0000_0001);
    apb(1'b0, `VCC_OFF_IRQ_STAT, 32'h0000_0000);
    chk("flag sticky", 32'h0000_0001, rd);
    apb(1'b1, `VCC_OFF_GLOBAL, 32'h0000_0000);
    settle(0);
    chk("gie off", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, `VCC_OFF_GLOBAL, 32'h0000_0001);
    apb(1'b1, `VCC_OFF_IRQ_MASK, 32'h0000_0000);
    settle(0);
    chk("mask off", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, `VCC_OFF_IRQ_MASK, 32'h0000_0001);
    apb(1'b0, `VCC_OFF_STATUS, 32'h0000_0000);
    apb(1'b1, `VCC_OFF_IRQ_STAT, 32'h0000_0000);
    settle(4);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    @(posedge clk) halt <= 1'b1;
    raw <= 1'b1;
    settle(4);
    chk("halt no flag", 32'h0000_0000, {31'h0, irq});
    $display("test interrupt done");
    results;
  end
endmodule
